// File: led_driver_control_registers.sv
// Overview of operation
// - software enable, reset 1, OR external pin
// - positive scaling input enable, reset 1
// - negative scaling input enable, reset 1
// - four-bit overvoltage code decoded to volts
// - lock set and clear bits for mode
// - eighteen-bit dimming period, reset 300 hex
// - eight-bit dimming duty, reset FF
// - ten-bit channel enable mask, reset 3FF
// - all-off bit forces every channel off
// - fail clear with channel enabled clears fail
// - strobe select: parallel or sequenced drive
// - two-bit converter rate, 150 to 1200 kHz
// - per-channel current level, reset FF
// - global current scale, reset FF
// - target answers serial address 76 hex
`timescale 1ns/1ps
`default_nettype none
`include "led_ctrl_regs.svh"

module led_driver_control_registers
  import led_ctrl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  input  wire logic        ext_enable_in,
  input  wire logic [9:0]  channel_fail_in,
  output logic             chip_active_out,
  output logic             pos_scaling_on_out,
  output logic             neg_scaling_on_out,
  output logic [3:0]       overvoltage_code_out,
  output logic [6:0]       overvoltage_volts_out,
  output logic             serial_mode_lock_out,
  output logic [17:0]      dimming_period_out,
  output logic [7:0]       dimming_duty_out,
  output logic [9:0]       channel_on_out,
  output logic [9:0]       channel_failed_out,
  output logic             flash_sequence_out,
  output logic [1:0]       converter_rate_out,
  output logic [10:0]      converter_khz_out,
  output logic [79:0]      channel_level_out,
  output logic [7:0]       global_scale_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [6:0] ovp_volts(input logic [3:0] code);
    logic [6:0] steps;
    steps = {3'h0, code - `OVP_MIN_CODE};
    if (code < `OVP_MIN_CODE)
      ovp_volts = 7'h00;
    else if (code == `OVP_TOP_CODE)
      ovp_volts = `OVP_TOP_V;
    else
      ovp_volts = `OVP_BASE_V + 7'(steps * `OVP_STEP_V);
  endfunction : ovp_volts

  function automatic logic [10:0] rate_khz(input logic [1:0] code);
    rate_khz = `BOOST_BASE_KHZ << code;
  endfunction : rate_khz

  // ----------------------------------------------------------------
  // serial line sampling
  // ----------------------------------------------------------------
  logic scl_q_r;
  logic sda_q_r;
  logic scl_p_r;
  logic sda_p_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= scl_in;
      sda_q_r <= sda_in;
      scl_p_r <= scl_q_r;
      sda_p_r <= sda_q_r;
    end
  end

  assign scl_rise   = scl_q_r & ~scl_p_r;
  assign scl_fall   = ~scl_q_r & scl_p_r;
  assign start_seen = scl_q_r & scl_p_r & sda_p_r & ~sda_q_r;
  assign stop_seen  = scl_q_r & scl_p_r & ~sda_p_r & sda_q_r;

  // ----------------------------------------------------------------
  // serial target state machine
  // ----------------------------------------------------------------
  serial_state_t state_r;
  logic [3:0]    bit_cnt_r;
  byte_t         shift_r;
  byte_t         index_r;
  byte_t         data_r;
  logic          wr_pulse_r;

  // only writes are served; a read address is left unanswered
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r      <= ST_IDLE;
      bit_cnt_r    <= 4'h0;
      shift_r      <= 8'h00;
      index_r      <= 8'h00;
      data_r       <= 8'h00;
      wr_pulse_r   <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end
    else
    begin
      wr_pulse_r <= 1'b0;
      if (stop_seen)
      begin
        state_r      <= ST_IDLE;
        sda_oe_n_out <= 1'b1;
      end
      else if (start_seen)
      begin
        state_r      <= ST_ADDR;
        bit_cnt_r    <= 4'h0;
        sda_oe_n_out <= 1'b1;
      end
      else
      begin
        case (state_r)
          ST_ADDR, ST_INDEX, ST_DATA:
          begin
            if (scl_rise)
            begin
              shift_r   <= {shift_r[6:0], sda_q_r};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            // counts to eight, so the fall right after start is no byte end
            else if (scl_fall && bit_cnt_r == 4'h8)
            begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR && shift_r == {`TARGET_ADDR, 1'b0})
              begin
                state_r      <= ST_ACK_ADDR;
                sda_oe_n_out <= 1'b0;
              end
              else if (state_r == ST_ADDR)
                state_r <= ST_IGNORE;
              else if (state_r == ST_INDEX)
              begin
                index_r      <= shift_r;
                state_r      <= ST_ACK_INDEX;
                sda_oe_n_out <= 1'b0;
              end
              else
              begin
                data_r       <= shift_r;
                state_r      <= ST_ACK_DATA;
                sda_oe_n_out <= 1'b0;
              end
            end
          end
          ST_ACK_ADDR:
          begin
            if (scl_fall)
            begin
              state_r      <= ST_INDEX;
              sda_oe_n_out <= 1'b1;
            end
          end
          ST_ACK_INDEX:
          begin
            if (scl_fall)
            begin
              state_r      <= ST_DATA;
              sda_oe_n_out <= 1'b1;
            end
          end
          ST_ACK_DATA:
          begin
            // one data byte per write; further bytes go unanswered
            if (scl_fall)
            begin
              state_r      <= ST_IGNORE;
              sda_oe_n_out <= 1'b1;
              wr_pulse_r   <= 1'b1;
            end
          end
          ST_IDLE, ST_IGNORE:
            sda_oe_n_out <= 1'b1;
          default:
            state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // line is only ever pulled low
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic        sw_enable_r;
  logic        pos_enable_r;
  logic        neg_enable_r;
  logic [3:0]  ovp_r;
  logic        lock_set_r;
  logic        lock_clear_r;
  logic [17:0] period_r;
  byte_t       duty_r;
  logic [9:0]  mask_r;
  logic        all_off_r;
  logic        fail_clear_r;
  logic        flash_r;
  logic [1:0]  rate_r;
  byte_t       level_r [10];
  byte_t       global_r;
  logic [3:0]  level_sel;

  assign level_sel = index_r[3:0];

  // reserved bits are dropped on write
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_enable_r  <= 1'b1;
      pos_enable_r <= 1'b1;
      neg_enable_r <= 1'b1;
      ovp_r        <= `RST_OVP;
      lock_set_r   <= 1'b0;
      lock_clear_r <= 1'b0;
      period_r     <= `RST_PERIOD;
      duty_r       <= `RST_DUTY;
      mask_r       <= `RST_MASK;
      all_off_r    <= 1'b0;
      fail_clear_r <= 1'b0;
      flash_r      <= 1'b0;
      rate_r       <= `RST_RATE;
      global_r     <= `RST_LEVEL;
      for (int i = 0; i < 10; i++)
        level_r[i] <= `RST_LEVEL;
    end
    else if (wr_pulse_r)
    begin
      case (index_r)
        `IDX_CONTROL:
        begin
          sw_enable_r  <= data_r[`BIT_SW_ENABLE];
          pos_enable_r <= data_r[`BIT_POS_ENABLE];
          neg_enable_r <= data_r[`BIT_NEG_ENABLE];
          ovp_r        <= data_r[7:4];
        end
        `IDX_SERIAL_MODE:
        begin
          lock_set_r   <= data_r[`BIT_LOCK_SET];
          lock_clear_r <= data_r[`BIT_LOCK_CLEAR];
        end
        `IDX_PERIOD_LO:  period_r[5:0]   <= data_r[5:0];
        `IDX_PERIOD_MID: period_r[11:6]  <= data_r[5:0];
        `IDX_PERIOD_HI:  period_r[17:12] <= data_r[5:0];
        `IDX_DUTY:       duty_r          <= data_r;
        `IDX_MASK_LO:    mask_r[4:0]     <= data_r[4:0];
        `IDX_MASK_HI:
        begin
          mask_r[9:5]  <= data_r[4:0];
          all_off_r    <= data_r[`BIT_ALL_OFF];
          fail_clear_r <= data_r[`BIT_FAIL_CLEAR];
          flash_r      <= data_r[`BIT_FLASH_SEQ];
        end
        `IDX_CONVERTER:  rate_r   <= data_r[1:0];
        `IDX_GLOBAL:     global_r <= data_r;
        default:
        begin
          if (index_r >= `IDX_LEVEL_FIRST && index_r <= `IDX_LEVEL_LAST)
            level_r[level_sel] <= data_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode lock and channel fail latches
  // ----------------------------------------------------------------
  logic       lock_r;
  logic [9:0] fail_r;
  logic [9:0] fail_release;

  // fail clears only on channels enabled again; a new fault wins
  assign fail_release = fail_clear_r && !all_off_r ? mask_r : 10'h000;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_r <= 1'b0;
      fail_r <= 10'h000;
    end
    else
    begin
      if (lock_clear_r)
        lock_r <= 1'b0;
      else if (lock_set_r)
        lock_r <= 1'b1;
      fail_r <= channel_fail_in | (fail_r & ~fail_release);
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chip_active_out       <= 1'b0;
      pos_scaling_on_out    <= 1'b0;
      neg_scaling_on_out    <= 1'b0;
      overvoltage_code_out  <= 4'h0;
      overvoltage_volts_out <= 7'h00;
      serial_mode_lock_out  <= 1'b0;
      dimming_period_out    <= 18'h00000;
      dimming_duty_out      <= 8'h00;
      channel_on_out        <= 10'h000;
      channel_failed_out    <= 10'h000;
      flash_sequence_out    <= 1'b0;
      converter_rate_out    <= 2'h0;
      converter_khz_out     <= 11'h000;
      channel_level_out     <= 80'h0;
      global_scale_out      <= 8'h00;
    end
    else
    begin
      chip_active_out       <= sw_enable_r | ext_enable_in;
      pos_scaling_on_out    <= pos_enable_r;
      neg_scaling_on_out    <= neg_enable_r;
      overvoltage_code_out  <= ovp_r;
      overvoltage_volts_out <= ovp_volts(ovp_r);
      serial_mode_lock_out  <= lock_r;
      dimming_period_out    <= period_r;
      dimming_duty_out      <= duty_r;
      channel_on_out        <= all_off_r ? 10'h000 : mask_r & ~fail_r;
      channel_failed_out    <= fail_r;
      flash_sequence_out    <= flash_r;
      converter_rate_out    <= rate_r;
      converter_khz_out     <= rate_khz(rate_r);
      global_scale_out      <= global_r;
      for (int i = 0; i < 10; i++)
        channel_level_out[i*8 +: 8] <= level_r[i];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_CHIP_ACTIVE: assert property (@(posedge clk_in) disable iff (!rst_n)
    !$past(sw_enable_r) && !$past(ext_enable_in) |-> !chip_active_out)
    else $error("chip active without any enable");
  AST_ALL_OFF: assert property (@(posedge clk_in) disable iff (!rst_n)
    all_off_r |=> channel_on_out == 10'h000)
    else $error("channel on while all off");
  AST_MASK: assert property (@(posedge clk_in) disable iff (!rst_n)
    ##1 (channel_on_out & ~$past(mask_r)) == 10'h000)
    else $error("masked channel driven");
  AST_ADDR_ACK: assert property (@(posedge clk_in) disable iff (!rst_n)
    $fell(sda_oe_n_out) && state_r == ST_ACK_ADDR |-> shift_r[7:1] == `TARGET_ADDR)
    else $error("acknowledged wrong address");
  AST_WRITE_AFTER_ACK: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr_pulse_r |-> $past(state_r) == ST_ACK_DATA && state_r == ST_IGNORE)
    else $error("write not after data acknowledge");
  AST_LOCK: assert property (@(posedge clk_in) disable iff (!rst_n)
    lock_set_r && !lock_clear_r |=> ##1 serial_mode_lock_out)
    else $error("lock not taken");
  AST_FAIL_CLEAR: assert property (@(posedge clk_in) disable iff (!rst_n)
    fail_clear_r && !all_off_r |=> (fail_r & $past(mask_r) & ~$past(channel_fail_in)) == 10'h000)
    else $error("fail not cleared");
  AST_FAIL_SET: assert property (@(posedge clk_in) disable iff (!rst_n)
    ##1 ($past(channel_fail_in) & ~fail_r) == 10'h000)
    else $error("fault lost against clear");
  AST_BOOST: assert property (@(posedge clk_in) disable iff (!rst_n)
    ##1 $past(rate_r) == 2'h3 |-> converter_khz_out == 11'h4B0)
    else $error("top converter rate wrong");
  AST_OVP: assert property (@(posedge clk_in) disable iff (!rst_n)
    ovp_r == 4'h3 |=> overvoltage_volts_out == 7'h0F)
    else $error("overvoltage decode wrong");
  AST_DEFAULTS: assert property (@(posedge clk_in) disable iff (!rst_n)
    !$past(rst_n) |-> period_r == `RST_PERIOD && duty_r == `RST_DUTY && mask_r == `RST_MASK)
    else $error("defaults missing after reset");

  COV_WRITE: cover property (@(posedge clk_in) disable iff (!rst_n) wr_pulse_r);
  COV_ALL_OFF: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(all_off_r));
  COV_LOCK: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(serial_mode_lock_out));

endmodule : led_driver_control_registers
`default_nettype wire

// File: led_ctrl_regs.svh
`ifndef LED_CTRL_REGS_SVH
`define LED_CTRL_REGS_SVH

// ----------------------------------------------------------------
// serial target address and register indices
// ----------------------------------------------------------------
`define TARGET_ADDR        7'h76
`define IDX_CONTROL        8'h00
`define IDX_SERIAL_MODE    8'h01
`define IDX_PERIOD_LO      8'h04
`define IDX_PERIOD_MID     8'h05
`define IDX_PERIOD_HI      8'h06
`define IDX_DUTY           8'h07
`define IDX_MASK_LO        8'h08
`define IDX_MASK_HI        8'h09
`define IDX_CONVERTER      8'h14
`define IDX_LEVEL_FIRST    8'hF0
`define IDX_LEVEL_LAST     8'hF9
`define IDX_GLOBAL         8'hFA

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_SW_ENABLE      0
`define BIT_POS_ENABLE     1
`define BIT_NEG_ENABLE     2
`define BIT_LOCK_SET       0
`define BIT_LOCK_CLEAR     1
`define BIT_ALL_OFF        5
`define BIT_FAIL_CLEAR     6
`define BIT_FLASH_SEQ      7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_OVP            4'hF
`define RST_PERIOD         18'h00300
`define RST_DUTY           8'hFF
`define RST_MASK           10'h3FF
`define RST_RATE           2'h2
`define RST_LEVEL          8'hFF

// ----------------------------------------------------------------
// decode constants
// ----------------------------------------------------------------
`define OVP_MIN_CODE       4'h2
`define OVP_TOP_CODE       4'hF
`define OVP_BASE_V         7'h0B
`define OVP_STEP_V         7'h04
`define OVP_TOP_V          7'h3E
`define BOOST_BASE_KHZ     11'h096

`endif

// File: led_ctrl_pkg.sv
`default_nettype none
package led_ctrl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_ADDR      = 3'h1,
    ST_ACK_ADDR  = 3'h3,
    ST_INDEX     = 3'h2,
    ST_ACK_INDEX = 3'h6,
    ST_DATA      = 3'h7,
    ST_ACK_DATA  = 3'h5,
    ST_IGNORE    = 3'h4
  } serial_state_t;

  typedef logic [7:0] byte_t;

endpackage : led_ctrl_pkg
`default_nettype wire

// File: led_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none

module led_i2c_host
  import led_ctrl_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // ----------------------------------------------------------------
  // serial host model
  // ----------------------------------------------------------------
  // twice the minimum phase, so slow sampling in the target still holds
  localparam int HALF = 8;

  initial
  begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  // data moves only while the clock is low, never with the clock edge itself
  task automatic put_bit(input logic b, output logic seen);
    tick(2);
    sda_low_out <= ~b;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    seen = sda_in;
    scl_out <= 1'b0;
  endtask : put_bit

  task automatic put_byte(input byte_t b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : put_byte

  // acks: address, index, data, extra byte
  task automatic xfer(input byte_t adr, input byte_t idx, input byte_t dat,
                      input logic extra, output logic [3:0] acks);
    tick(HALF);
    sda_low_out <= 1'b1;
    tick(HALF);
    scl_out <= 1'b0;
    put_byte(adr, acks[3]);
    put_byte(idx, acks[2]);
    put_byte(dat, acks[1]);
    acks[0] = 1'b0;
    if (extra)
      put_byte(dat, acks[0]);
    tick(2);
    sda_low_out <= 1'b1;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    sda_low_out <= 1'b0;
    tick(HALF);
  endtask : xfer

endmodule : led_i2c_host
`default_nettype wire

// File: led_driver_control_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "led_ctrl_regs.svh"

module led_driver_control_registers_bench
  import led_ctrl_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic        ext_enable;
  logic [9:0]  channel_fail;
  logic        scl;
  logic        sda_low;
  wire  logic  sda_line;
  logic        sda_out;
  logic        sda_oe_n;
  logic        active;
  logic        pos_on;
  logic        neg_on;
  logic [3:0]  ovp_code;
  logic [6:0]  ovp_volts;
  logic        lock;
  logic [17:0] period;
  logic [7:0]  duty;
  logic [9:0]  chan_on;
  logic [9:0]  chan_failed;
  logic        flash;
  logic [1:0]  rate;
  logic [10:0] khz;
  logic [79:0] levels;
  logic [7:0]  global_scale;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [3:0]  acks;
  logic [5:0]  lock_exp = 6'h23;
  byte_t       lock_dat [6] = '{8'h01, 8'h00, 8'h03, 8'h00, 8'h02, 8'h01};

  // pull-up on the data wire; either party may pull it low
  assign sda_line = ~sda_low & (sda_oe_n | sda_out);

  led_driver_control_registers dut (
    .clk_in                (clk),
    .nrst_in               (nrst),
    .scl_in                (scl),
    .sda_in                (sda_line),
    .sda_out               (sda_out),
    .sda_oe_n_out          (sda_oe_n),
    .ext_enable_in         (ext_enable),
    .channel_fail_in       (channel_fail),
    .chip_active_out       (active),
    .pos_scaling_on_out    (pos_on),
    .neg_scaling_on_out    (neg_on),
    .overvoltage_code_out  (ovp_code),
    .overvoltage_volts_out (ovp_volts),
    .serial_mode_lock_out  (lock),
    .dimming_period_out    (period),
    .dimming_duty_out      (duty),
    .channel_on_out        (chan_on),
    .channel_failed_out    (chan_failed),
    .flash_sequence_out    (flash),
    .converter_rate_out    (rate),
    .converter_khz_out     (khz),
    .channel_level_out     (levels),
    .global_scale_out      (global_scale)
  );

  led_i2c_host host (
    .clk_in      (clk),
    .sda_in      (sda_line),
    .scl_out     (scl),
    .sda_low_out (sda_low)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input byte_t idx, input byte_t d);
    host.xfer({`TARGET_ADDR, 1'b0}, idx, d, 1'b0, acks);
    chk("acks", 80'hE, 80'(acks));
  endtask : wr

  // ----------------------------------------------------------------
  // clock, reset, watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // whole run is near 28k cycles of serial traffic
  initial
  begin
    repeat (80000) @(posedge clk);
    fail_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    ext_enable = 1'b0;
    channel_fail = 10'h000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    chk("active", 80'h1, 80'(active));
    chk("pos", 80'h1, 80'(pos_on));
    chk("neg", 80'h1, 80'(neg_on));
    chk("ovp", 80'hF3E, 80'({ovp_code, 1'b0, ovp_volts}));
    chk("lock", 80'h0, 80'(lock));
    chk("period", 80'h300, 80'(period));
    chk("duty", 80'hFF, 80'(duty));
    chk("chan_on", 80'h3FF, 80'(chan_on));
    chk("failed", 80'h0, 80'({flash, chan_failed}));
    chk("rate", 80'h2258, 80'({rate, 1'b0, khz}));
    chk("levels", {10{8'hFF}}, levels);
    chk("global", 80'hFF, 80'(global_scale));
    $display("test defaults done");

    wr(`IDX_CONTROL, 8'h58);
    chk("ctl", 80'h0_0_0_5, 80'({active, pos_on, neg_on, 1'b0, ovp_code}));
    ext_enable <= 1'b1;
    repeat (3) @(posedge clk);
    chk("active", 80'h1, 80'(active));
    ext_enable <= 1'b0;
    for (int c = 0; c < 16; c++)
    begin
      wr(`IDX_CONTROL, {4'(c), 4'h7});
      chk("volts", 80'(c < 2 ? 0 : (c == 15 ? 62 : 11 + 4 * (c - 2))), 80'(ovp_volts));
      chk("enables", 80'h7, 80'({active, pos_on, neg_on}));
    end
    $display("test control done");

    for (int i = 0; i < 6; i++)
    begin
      wr(`IDX_SERIAL_MODE, lock_dat[i]);
      chk("lock", 80'(lock_exp[i]), 80'(lock));
    end
    $display("test lock done");

    wr(`IDX_PERIOD_LO, 8'hFF);
    chk("period", 80'h0033F, 80'(period));
    wr(`IDX_PERIOD_MID, 8'h15);
    wr(`IDX_PERIOD_HI, 8'h2A);
    chk("period", 80'h2A57F, 80'(period));
    wr(`IDX_DUTY, 8'h80);
    chk("duty", 80'h80, 80'(duty));
    $display("test dimming done");

    wr(`IDX_MASK_LO, 8'h0A);
    wr(`IDX_MASK_HI, 8'h03);
    chk("chan_on", 80'h06A, 80'(chan_on));
    channel_fail <= 10'h002;
    @(posedge clk);
    channel_fail <= 10'h000;
    repeat (4) @(posedge clk);
    chk("fail", 80'h002_068, 80'({chan_failed, 2'b00, chan_on}));
    wr(`IDX_MASK_HI, 8'h23);
    chk("chan_on", 80'h0, 80'(chan_on));
    wr(`IDX_MASK_HI, 8'h63);
    chk("failed", 80'h002, 80'(chan_failed));
    wr(`IDX_MASK_HI, 8'h43);
    chk("fail", 80'h000_06A, 80'({chan_failed, 2'b00, chan_on}));
    wr(`IDX_MASK_HI, 8'h83);
    chk("flash", 80'h1_06A, 80'({1'b0, flash, 2'b00, chan_on}));
    $display("test channels done");

    for (int c = 0; c < 4; c++)
    begin
      wr(`IDX_CONVERTER, 8'hFC | 8'(c));
      chk("rate", 80'(c), 80'(rate));
      chk("khz", 80'(150 << c), 80'(khz));
    end
    // codes kept small so no channel is overdriven
    for (int i = 0; i < 10; i++)
    begin
      wr(`IDX_LEVEL_FIRST + 8'(i), 8'h10 + 8'(i));
      chk("level", 80'(8'h10 + 8'(i)), 80'(levels[8 * i +: 8]));
    end
    wr(`IDX_GLOBAL, 8'h40);
    chk("global", 80'h40, 80'(global_scale));
    $display("test current done");

    host.xfer({7'h75, 1'b0}, `IDX_DUTY, 8'h11, 1'b0, acks);
    chk("acks", 80'h0, 80'(acks));
    host.xfer({`TARGET_ADDR, 1'b1}, `IDX_DUTY, 8'h12, 1'b0, acks);
    chk("acks", 80'h0, 80'(acks));
    wr(8'h30, 8'h55);
    chk("duty", 80'h80, 80'(duty));
    host.xfer({`TARGET_ADDR, 1'b0}, `IDX_DUTY, 8'h22, 1'b1, acks);
    chk("acks", 80'hE, 80'(acks));
    chk("duty", 80'h22, 80'(duty));
    $display("test refusals done");
    tally_and_finish();
  end

endmodule : led_driver_control_registers_bench
`default_nettype wire
